// *** hdl/ais_fifo.sv ***
/*
  Synchronous FIFO with valid/ready on both sides.
  Assumes one clock and a synchronous active-high reset; DEPTH is a power
  of two.
*/
`timescale 1ns/1ns
module ais_fifo #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 16
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic [WIDTH-1:0]      out_data_o,
  output logic [$clog2(DEPTH):0] level_o
);

  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wr_ptr_reg;
  logic [PW-1:0]    rd_ptr_reg;
  logic [PW:0]      count_reg;
  logic             push;
  logic             pop;

  // Full refuses the source, so nothing is ever overwritten.
  assign in_ready_o  = (count_reg != (PW+1)'(DEPTH));
  assign out_valid_o = (count_reg != '0);
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;
  assign out_data_o  = mem[rd_ptr_reg];
  assign level_o     = count_reg;

  // Storage has no reset; only pointers and the count need one.
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data_i;
    end
  end

  // Pointer and occupancy bookkeeping.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      wr_ptr_reg <= wr_ptr_reg + PW'(push);
      rd_ptr_reg <= rd_ptr_reg + PW'(pop);
      count_reg  <= count_reg + (PW+1)'(push) - (PW+1)'(pop);
    end
  end

  default clocking fcb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  a_fifo_full_stall: assert property (
    (count_reg == (PW+1)'(DEPTH)) |-> !in_ready_o)
    else $error("FIFO accepts data while full.");
  a_fifo_count_step: assert property (
    push && !pop |=> count_reg == $past(count_reg) + 1'b1)
    else $error("FIFO count did not follow a lone push.");
  c_fifo_fills: cover property (count_reg == (PW+1)'(DEPTH));

endmodule

// *** hdl/ais_pkg.sv ***
/*
  Shared constants for the auxiliary input scaling block: register map,
  field layouts, reset values, arithmetic widths and the polarity modes.
  Assumes a 32-bit classic Wishbone bus with byte addresses.
*/
package ais_pkg;

  // Datapath widths. Samples and results are signed millivolts.
  localparam int RAW_W    = 16;
  localparam int SCALE_W  = 16;
  localparam int OFFSET_W = 20;
  localparam int OUT_W    = 20;
  localparam int CALC_W   = 34;
  localparam int CHAN_W   = 2;
  localparam int NUM_CH   = 3;

  // Bus layout: bits [7:6] zero, [5:4] channel, [3:2] field.
  localparam int ADR_W    = 8;
  localparam logic [CHAN_W-1:0] CH_LIMIT = 2'h3;
  localparam logic [1:0] FLD_POL    = 2'h0;
  localparam logic [1:0] FLD_OFFSET = 2'h1;
  localparam logic [1:0] FLD_SCALE  = 2'h2;
  localparam logic [1:0] FLD_RESULT = 2'h3;
  localparam logic [ADR_W-1:0] ADDR_STATUS = 8'h30;

  // Status word layout.
  localparam int ST_LEVEL_LSB = 0;
  localparam int ST_FULL_BIT  = 8;
  localparam int ST_EMPTY_BIT = 9;

  // Gain in tenths of a percent, offset in thousandths of a percent.
  localparam logic signed [SCALE_W-1:0]  SCALE_RST  = 16'sh03e8;
  localparam logic signed [SCALE_W-1:0]  SCALE_MAX  = 16'sh1f40;
  localparam logic signed [SCALE_W-1:0]  SCALE_MIN  = -16'sh1f40;
  localparam logic signed [OFFSET_W-1:0] OFFSET_RST = 20'sh00000;
  localparam logic signed [OFFSET_W-1:0] OFFSET_MAX = 20'sh61a80;
  localparam logic signed [OFFSET_W-1:0] OFFSET_MIN = -20'sh61a80;

  // Raw*gain/1000 gives mV; offset/10 gives mV of the 10 V reference.
  localparam logic signed [CALC_W-1:0] GAIN_DIV = 34'sh0000003e8;
  localparam logic signed [CALC_W-1:0] BIAS_DIV = 34'sh00000000a;

  localparam int FIFO_DEPTH = 16;

  typedef enum logic [1:0] {
    POL_BIPOLAR  = 2'b00,
    POL_POS_ONLY = 2'b01,
    POL_NEG_ONLY = 2'b10
  } ais_pol_t;

  localparam ais_pol_t POL_RST = POL_BIPOLAR;

endpackage

// *** hdl/ais_top.sv ***
/*
  Auxiliary input scaling: three channels of gain, bias and polarity
  restriction applied to converter samples, with a Wishbone register file.
  Assumes samples arrive synchronous to clk_i, already digitised in signed
  millivolts with a channel tag, and that the consumer may stall.
*/
// Local design decisions: register access over Wishbone and the register addresses.
`timescale 1ns/1ns
// Functional notes
// - Three independent channels, each own settings.
// - Polarity 0 both, 1 positive, 2 negative.
// - Restriction judged after gain and bias.
// - Disallowed sign becomes zero, allowed passes.
// - Bias percent of 10 V, default zero.
// - Gain multiplies first, default 100 percent.
// - Output equals input*gain/100 plus 10*bias/100.
module ais_top
  import ais_pkg::*;
(
  input  wire logic                    clk_i,
  input  wire logic                    rst_i,
  input  wire logic                    wb_cyc_i,
  input  wire logic                    wb_stb_i,
  input  wire logic                    wb_we_i,
  input  wire logic [ADR_W-1:0]        wb_adr_i,
  input  wire logic [31:0]             wb_dat_i,
  input  wire logic [3:0]              wb_sel_i,
  output logic [31:0]                  wb_dat_o,
  output logic                         wb_ack_o,
  input  wire logic                    sample_valid_i,
  output logic                         sample_ready_o,
  input  wire logic [CHAN_W-1:0]       sample_chan_i,
  input  wire logic signed [RAW_W-1:0] raw_sample_i,
  output logic                         scaled_valid_o,
  input  wire logic                    scaled_ready_i,
  output logic [CHAN_W-1:0]            scaled_chan_o,
  output logic signed [OUT_W-1:0]      scaled_sample_o
);

  localparam int FW = CHAN_W + RAW_W;
  localparam int LW = $clog2(FIFO_DEPTH) + 1;

  // Merge a bus write into an existing word, lane by lane.
  function automatic logic [31:0] ais_merge(input logic [31:0] old_w,
                                            input logic [31:0] new_w,
                                            input logic [3:0]  sel);
    logic [31:0] res;
    res = old_w;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[8*b +: 8] = new_w[8*b +: 8];
      end
    end
    return res;
  endfunction

  // Saturate a written value into its legal setting range.
  function automatic logic signed [31:0] ais_clamp(
      input logic signed [31:0] v,
      input logic signed [31:0] lo,
      input logic signed [31:0] hi);
    return (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  // Gain then bias; 34 bits hold the extreme product plus offset.
  function automatic logic signed [CALC_W-1:0] ais_scale(
      input logic signed [RAW_W-1:0]    raw,
      input logic signed [SCALE_W-1:0]  gain,
      input logic signed [OFFSET_W-1:0] off);
    logic signed [CALC_W-1:0] prod;
    prod = CALC_W'(raw) * CALC_W'(gain);
    return prod / GAIN_DIV + CALC_W'(off) / BIAS_DIV;
  endfunction

  // Replace a value of the disallowed sign by zero.
  function automatic logic signed [CALC_W-1:0] ais_restrict(
      input logic signed [CALC_W-1:0] v,
      input ais_pol_t                 pol);
    logic signed [CALC_W-1:0] res;
    res = v;
    if (pol == POL_POS_ONLY && v < 0) begin
      res = '0;
    end else if (pol == POL_NEG_ONLY && v > 0) begin
      res = '0;
    end
    return res;
  endfunction

  // Per-channel settings and last results.
  ais_pol_t                 pol_reg    [NUM_CH];
  logic signed [SCALE_W-1:0]  scale_reg  [NUM_CH];
  logic signed [OFFSET_W-1:0] offset_reg [NUM_CH];
  logic signed [OUT_W-1:0]    result_reg [NUM_CH];

  logic                    ack_reg;
  logic [31:0]             dat_reg;
  logic                    scaled_valid_reg;
  logic [CHAN_W-1:0]       scaled_chan_reg;
  logic signed [OUT_W-1:0] scaled_sample_reg;

  // Bus decode.
  logic [CHAN_W-1:0] acc_ch;
  logic [1:0]        acc_fld;
  logic              ch_hit;
  logic              st_hit;
  logic              bus_take;
  logic              wr_take;
  assign acc_ch   = wb_adr_i[5:4];
  assign acc_fld  = wb_adr_i[3:2];
  assign ch_hit   = (wb_adr_i[7:6] == 2'h0) && (acc_ch != CH_LIMIT);
  assign st_hit   = (wb_adr_i[7:2] == ADDR_STATUS[7:2]);
  assign bus_take = wb_cyc_i & wb_stb_i & ~ack_reg;
  assign wr_take  = bus_take & wb_we_i & ch_hit;

  // FIFO between the converter side and the arithmetic.
  logic          fifo_in_valid;
  logic          fifo_out_valid;
  logic          pop;
  logic [FW-1:0] fifo_head;
  logic [LW-1:0] fifo_level;
  // Channel tag 3 names no input; it is accepted and discarded.
  assign fifo_in_valid = sample_valid_i & (sample_chan_i != CH_LIMIT);

  ais_fifo #(
    .WIDTH (FW),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .in_valid_i  (fifo_in_valid),
    .in_ready_o  (sample_ready_o),
    .in_data_i   ({sample_chan_i, raw_sample_i}),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (pop),
    .out_data_o  (fifo_head),
    .level_o     (fifo_level)
  );

  // Head sample and the settings of its channel.
  logic [CHAN_W-1:0]          head_chan;
  logic signed [RAW_W-1:0]    head_raw;
  ais_pol_t                   head_pol;
  logic signed [SCALE_W-1:0]  head_scale;
  logic signed [OFFSET_W-1:0] head_offset;
  logic signed [CALC_W-1:0]   head_sum;
  logic signed [CALC_W-1:0]   head_out;
  assign head_chan   = fifo_head[FW-1 -: CHAN_W];
  assign head_raw    = fifo_head[RAW_W-1:0];
  assign head_pol    = (head_chan == 2'h1) ? pol_reg[1] :
                       (head_chan == 2'h2) ? pol_reg[2] : pol_reg[0];
  assign head_scale  = (head_chan == 2'h1) ? scale_reg[1] :
                       (head_chan == 2'h2) ? scale_reg[2] : scale_reg[0];
  assign head_offset = (head_chan == 2'h1) ? offset_reg[1] :
                       (head_chan == 2'h2) ? offset_reg[2] : offset_reg[0];
  assign head_sum    = ais_scale(head_raw, head_scale, head_offset);
  assign head_out    = ais_restrict(head_sum, head_pol);

  // One sample leaves the FIFO only when the output stage can take it.
  assign pop = fifo_out_valid & (~scaled_valid_reg | scaled_ready_i);

  // Read selection; unmapped addresses read as zero.
  logic [31:0] ch_word;
  logic [31:0] st_word;
  logic [31:0] rd_word;
  assign ch_word = (acc_fld == FLD_POL)    ? {30'h0, pol_reg[acc_ch]} :
                   (acc_fld == FLD_OFFSET) ? 32'(offset_reg[acc_ch]) :
                   (acc_fld == FLD_SCALE)  ? 32'(scale_reg[acc_ch]) :
                   32'(result_reg[acc_ch]);
  // The flags are inverted at one bit and only then widened: inverting
  // inside a widening cast may fill the upper bits with ones.
  logic st_full;
  logic st_empty;
  assign st_full  = ~sample_ready_o;
  assign st_empty = ~fifo_out_valid;
  assign st_word = (32'(fifo_level) << ST_LEVEL_LSB)
                 | (32'(st_full) << ST_FULL_BIT)
                 | (32'(st_empty) << ST_EMPTY_BIT);
  assign rd_word = ch_hit ? ch_word : (st_hit ? st_word : 32'h0);

  // Byte-lane merge and saturation of incoming settings.
  logic [31:0]                wr_word;
  logic signed [31:0]         wr_scale;
  logic signed [31:0]         wr_offset;
  logic                       wr_pol_ok;
  assign wr_word   = ais_merge(rd_word, wb_dat_i, wb_sel_i);
  assign wr_scale  = ais_clamp(wr_word, 32'(SCALE_MIN), 32'(SCALE_MAX));
  assign wr_offset = ais_clamp(wr_word, 32'(OFFSET_MIN), 32'(OFFSET_MAX));
  // Code 3 is not a polarity mode, so such a write leaves it unchanged.
  assign wr_pol_ok = (wr_word[1:0] != 2'b11);

  // Bus handshake: ack one cycle after the request is seen.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      dat_reg <= 32'h0;
    end else begin
      ack_reg <= bus_take;
      if (bus_take && !wb_we_i) begin
        dat_reg <= rd_word;
      end
    end
  end

  // Each channel keeps its own settings and last result.
  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    logic sel_ch;
    assign sel_ch = wr_take && (acc_ch == CHAN_W'(c));

    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        pol_reg[c]    <= POL_RST;
        scale_reg[c]  <= SCALE_RST;
        offset_reg[c] <= OFFSET_RST;
      end else if (sel_ch) begin
        if (acc_fld == FLD_POL && wr_pol_ok) begin
          pol_reg[c] <= ais_pol_t'(wr_word[1:0]);
        end
        if (acc_fld == FLD_SCALE) begin
          scale_reg[c] <= wr_scale[SCALE_W-1:0];
        end
        if (acc_fld == FLD_OFFSET) begin
          offset_reg[c] <= wr_offset[OFFSET_W-1:0];
        end
      end
    end

    // Last conditioned value per channel, visible to software.
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        result_reg[c] <= '0;
      end else if (pop && head_chan == CHAN_W'(c)) begin
        result_reg[c] <= head_out[OUT_W-1:0];
      end
    end
  end

  // Output stage holds its word until the consumer takes it.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      scaled_valid_reg  <= 1'b0;
      scaled_chan_reg   <= '0;
      scaled_sample_reg <= '0;
    end else begin
      if (pop) begin
        scaled_valid_reg  <= 1'b1;
        scaled_chan_reg   <= head_chan;
        scaled_sample_reg <= head_out[OUT_W-1:0];
      end else if (scaled_ready_i) begin
        scaled_valid_reg  <= 1'b0;
      end
    end
  end

  assign wb_ack_o        = ack_reg;
  assign wb_dat_o        = dat_reg;
  assign scaled_valid_o  = scaled_valid_reg;
  assign scaled_chan_o   = scaled_chan_reg;
  assign scaled_sample_o = scaled_sample_reg;

  // Checks on the arithmetic, the settings and the bus.
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // Expected unrestricted value, written out term by term instead of
  // through ais_scale, so that a fault in the function cannot mask itself.
  logic signed [CALC_W-1:0] chk_prod;
  logic signed [CALC_W-1:0] chk_sum;
  assign chk_prod = CALC_W'(head_raw) * CALC_W'(head_scale);
  assign chk_sum  = chk_prod / GAIN_DIV + CALC_W'(head_offset) / BIAS_DIV;

  a_reset_defaults: assert property (
    $past(rst_i) |-> pol_reg[0] == POL_BIPOLAR
      && pol_reg[1] == POL_BIPOLAR && pol_reg[2] == POL_BIPOLAR)
    else $error("Polarity not bipolar after reset.");
  a_gain_default: assert property (
    $past(rst_i) |-> scale_reg[0] == SCALE_RST
      && scale_reg[1] == SCALE_RST && scale_reg[2] == SCALE_RST)
    else $error("Gain not 100 percent after reset.");
  a_bias_default: assert property (
    $past(rst_i) |-> offset_reg[0] == OFFSET_RST
      && offset_reg[1] == OFFSET_RST && offset_reg[2] == OFFSET_RST)
    else $error("Bias not zero after reset.");
  a_bipolar_formula: assert property (
    pop && head_pol == POL_BIPOLAR
      |=> scaled_sample_o == $past(chk_sum[OUT_W-1:0]))
    else $error("Bipolar output differs from gain and bias formula.");
  a_positive_clip: assert property (
    pop && head_pol == POL_POS_ONLY && chk_sum < 0
      |=> scaled_valid_o && scaled_sample_o == '0)
    else $error("Negative value passed in positive-only mode.");
  a_negative_clip: assert property (
    pop && head_pol == POL_NEG_ONLY
      |=> scaled_sample_o <= 0)
    else $error("Positive value passed in negative-only mode.");
  a_after_scaling: assert property (
    pop && head_pol == POL_POS_ONLY && head_raw < 0 && chk_sum > 0
      |=> scaled_sample_o == $past(chk_sum[OUT_W-1:0]))
    else $error("Restriction judged on raw input, not scaled value.");
  a_channel_kept: assert property (
    pop |=> scaled_chan_o == $past(head_chan) && scaled_chan_o != 2'h3)
    else $error("Output channel does not match its sample.");
  a_output_held: assert property (
    scaled_valid_o && !scaled_ready_i
      |=> scaled_valid_o && $stable(scaled_sample_o))
    else $error("Stalled output changed before it was taken.");
  a_ack_single: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("Bus ack not a single cycle after request.");

  // Saturation, and for polarity the refusal of code 3, must keep every setting inside its legal span, whatever
  // software writes; the arithmetic widths rely on it.
  a_gain_range: assert property (
    scale_reg[0] >= SCALE_MIN && scale_reg[0] <= SCALE_MAX
      && scale_reg[1] >= SCALE_MIN && scale_reg[1] <= SCALE_MAX
      && scale_reg[2] >= SCALE_MIN && scale_reg[2] <= SCALE_MAX)
    else $error("Gain setting outside its range.");
  a_bias_range: assert property (
    offset_reg[0] >= OFFSET_MIN && offset_reg[0] <= OFFSET_MAX
      && offset_reg[1] >= OFFSET_MIN && offset_reg[1] <= OFFSET_MAX
      && offset_reg[2] >= OFFSET_MIN && offset_reg[2] <= OFFSET_MAX)
    else $error("Bias setting outside its range.");
  a_pol_legal: assert property (
    pol_reg[0] != 2'b11 && pol_reg[1] != 2'b11 && pol_reg[2] != 2'b11)
    else $error("Polarity setting holds an undefined code.");

  // Values of the allowed sign must pass through the restriction intact.
  a_positive_pass: assert property (
    pop && head_pol == POL_POS_ONLY && chk_sum >= 0
      |=> scaled_sample_o == $past(chk_sum[OUT_W-1:0]))
    else $error("Allowed positive value altered in positive-only mode.");
  a_negative_pass: assert property (
    pop && head_pol == POL_NEG_ONLY && chk_sum <= 0
      |=> scaled_sample_o == $past(chk_sum[OUT_W-1:0]))
    else $error("Allowed negative value altered in negative-only mode.");

  // The software view of a channel follows what left the output stage.
  a_result_kept: assert property (
    pop && head_chan == 2'h1 |=> result_reg[1] == scaled_sample_o)
    else $error("Channel result register missed its sample.");
  a_pop_delivers: assert property (
    pop |=> scaled_valid_o)
    else $error("Popped sample did not reach the output stage.");

  c_pos_clip: cover property (pop && head_pol == POL_POS_ONLY
                              && chk_sum < 0);
  c_neg_clip: cover property (pop && head_pol == POL_NEG_ONLY
                              && chk_sum > 0);
  c_stall: cover property (scaled_valid_o && !scaled_ready_i
                           && !sample_ready_o);
  c_bus_write: cover property (wr_take && acc_fld == FLD_SCALE);

endmodule

// *** tb/ais_adc_model.sv ***
/*
  Behavioural converter front end that feeds tagged samples to the scaling
  block. Assumes the bench queues samples with push and sets the pacing.
*/
`timescale 1ns/1ns
module ais_adc_model
  import ais_pkg::*;
(
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  input  wire logic               ready_i,
  input  wire logic               slow_i,
  output logic                    valid_o,
  output logic [CHAN_W-1:0]       chan_o,
  output logic signed [RAW_W-1:0] raw_o
);
  logic [CHAN_W+RAW_W-1:0] pend_q[$];
  logic                    took;

  // Queue one sample for delivery in order.
  task automatic push(input logic [CHAN_W-1:0] c, input logic [RAW_W-1:0] r);
    pend_q.push_back({c, r});
  endtask

  initial begin
    valid_o = 1'b0;
    chan_o = '0;
    raw_o = '0;
  end

  // A sample is held until taken; slow pacing idles a cycle after each
  // transfer. Idle lines flip so that a stale value is never mistaken.
  always @(posedge clk_i) begin
    took = valid_o && ready_i && !rst_i;
    if (took) begin
      pend_q.delete(0);
    end
    if (!rst_i && pend_q.size() > 0 && !(took && slow_i)) begin
      valid_o <= 1'b1;
      {chan_o, raw_o} <= pend_q[0];
    end else begin
      valid_o <= 1'b0;
      chan_o <= ~chan_o;
      raw_o <= ~raw_o;
    end
  end
endmodule

// *** tb/tb.sv ***
/*
  Self-checking bench for the auxiliary input scaling block: Wishbone
  register access, converter model on the input, stalling consumer.
  Assumes the package constants; the bus master waits for ack as long as
  it takes, and only the run's cycle limit ends such a wait.
*/
`timescale 1ns/1ns
module tb
  import ais_pkg::*;
;
  logic clk_i = 1'b0, rst_i = 1'b1, slow = 1'b0;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
  logic [ADR_W-1:0] wb_adr_i = '0;
  logic [31:0] wb_dat_i = '0, wb_dat_o, q;
  logic [3:0] wb_sel_i = '0;
  logic [3:0] sel_v = 4'hf;
  logic sample_valid_i, sample_ready_o, scaled_valid_o, scaled_ready_i = 1'b1;
  logic [CHAN_W-1:0] sample_chan_i, scaled_chan_o;
  logic signed [RAW_W-1:0] raw_sample_i;
  logic signed [OUT_W-1:0] scaled_sample_o;
  logic [31:0] exp_q[$];
  int pol_s[3] = '{0, 0, 0}, gain_s[3] = '{1000, 1000, 1000};
  int offs_s[3] = '{0, 0, 0}, err_count = 0, checks = 0, cycles = 0;

  always #50 clk_i = ~clk_i;

  ais_top uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .sample_valid_i(sample_valid_i),
    .sample_ready_o(sample_ready_o), .sample_chan_i(sample_chan_i),
    .raw_sample_i(raw_sample_i), .scaled_valid_o(scaled_valid_o),
    .scaled_ready_i(scaled_ready_i), .scaled_chan_o(scaled_chan_o),
    .scaled_sample_o(scaled_sample_o));

  ais_adc_model adc (.clk_i(clk_i), .rst_i(rst_i), .ready_i(sample_ready_o),
    .slow_i(slow), .valid_o(sample_valid_i), .chan_o(sample_chan_i),
    .raw_o(raw_sample_i));

  task automatic results;
    $display("checks=%0d mismatches=%0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One classic cycle; the request stands until ack is seen at an edge.
  task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= sel_v;
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    wb(a, 1'b0, 32'h0);
    chk(q, exp);
  endtask

  task automatic set_ch(input int c, input int p, input int g, input int b);
    wb({2'h0, c[1:0], FLD_POL, 2'h0}, 1'b1, p);
    wb({2'h0, c[1:0], FLD_SCALE, 2'h0}, 1'b1, g);
    wb({2'h0, c[1:0], FLD_OFFSET, 2'h0}, 1'b1, b);
    pol_s[c] = p;
    gain_s[c] = g;
    offs_s[c] = b;
  endtask

  // Gain in tenths of a percent, bias in thousandths; each term truncates.
  function automatic logic [31:0] expv(input int c, input int raw);
    int v;
    v = raw * gain_s[c] / 1000 + offs_s[c] / 10;
    if (pol_s[c] == 1 && v < 0) v = 0;
    if (pol_s[c] == 2 && v > 0) v = 0;
    return v;
  endfunction

  task automatic send(input int c, input int raw);
    logic [31:0] v;
    adc.push(c[1:0], raw[15:0]);
    if (c < 3) begin
      v = expv(c, raw);
      exp_q.push_back({10'h0, c[1:0], v[19:0]});
    end
  endtask

  task automatic drain;
    int n;
    n = 0;
    while ((exp_q.size() > 0 || adc.pend_q.size() > 0) && n < 1000) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 1000) err_count++;
  endtask

  // Every delivered result must match the oldest outstanding expectation.
  always @(posedge clk_i) begin
    if (!rst_i && scaled_valid_o === 1'b1 && scaled_ready_i === 1'b1) begin
      // An output nobody expects can never match this all-ones word.
      if (exp_q.size() == 0)
        chk({10'h0, scaled_chan_o, scaled_sample_o}, 32'hffffffff);
      else
        chk({10'h0, scaled_chan_o, scaled_sample_o}, exp_q.pop_front());
    end
  end

  // Cuts a hang short; the full run needs only a few hundred cycles.
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      results;
    end
  end

  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int c = 0; c < 3; c++) begin
      rd_chk(8'(c * 16), 32'h0);
      rd_chk(8'(c * 16 + 4), 32'h0);
      rd_chk(8'(c * 16 + 8), 32'h3e8);
    end
    rd_chk(8'h30, 32'h200);
    rd_chk(8'h40, 32'h0);
    $display("test reset values done");
    send(0, 1234);
    send(1, -77);
    send(3, 500);
    send(2, 32767);
    drain();
    $display("test default path done");
    slow <= 1'b1;
    set_ch(0, 0, 2000, 12345);
    set_ch(1, 0, -500, -400000);
    set_ch(2, 0, 8000, 400000);
    send(0, -1001);
    send(1, 333);
    send(2, 32767);
    send(2, -32768);
    drain();
    rd_chk(8'h2c, expv(2, -32768));
    slow <= 1'b0;
    $display("test channel settings done");
    for (int p = 0; p < 3; p++) begin
      set_ch(1, p, 1000, -10000);
      send(1, 500);
      send(1, 3000);
      send(1, -200);
      drain();
    end
    wb(8'h10, 1'b1, 32'h3);
    rd_chk(8'h10, 32'h2);
    set_ch(1, 1, -1000, -10000);
    send(1, -3000);
    send(1, 300);
    drain();
    $display("test polarity done");
    wb(8'h08, 1'b1, 32'h7fff);
    rd_chk(8'h08, 32'h1f40);
    wb(8'h04, 1'b1, 32'hfff85ee0);
    rd_chk(8'h04, 32'hfff9e580);
    gain_s[0] = 8000;
    offs_s[0] = -400000;
    send(0, 100);
    drain();
    $display("test limits done");
    scaled_ready_i <= 1'b0;
    for (int i = 0; i < 20; i++) send(0, i * 10);
    for (int n = 0; n < 100 && sample_ready_o !== 1'b0; n++) @(posedge clk_i);
    rd_chk(8'h30, 32'h110);
    scaled_ready_i <= 1'b1;
    drain();
    rd_chk(8'h30, 32'h200);
    $display("test buffer fill done");
    sel_v = 4'h2;
    wb(8'h28, 1'b1, 32'h00000f00);
    sel_v = 4'hf;
    rd_chk(8'h28, 32'hf40);
    $display("test lane select done");
    results();
  end
endmodule
